// File: rtl/vlimit_pkg.sv
// Constants for the voltage limit and setpoint command bank.
// Assumes a word-level command engine in front of the bank.
package vlimit_pkg;
   localparam logic [7:0] CODE_FMT = 8'h20;
   localparam logic [7:0] CODE_NOM = 8'h21;
   localparam logic [7:0] CODE_CEIL = 8'h24;
   localparam logic [7:0] CODE_MHI = 8'h25;
   localparam logic [7:0] CODE_MLO = 8'h26;
   localparam logic [7:0] CODE_OVF = 8'h40;
   localparam logic [7:0] CODE_OVW = 8'h42;
   localparam logic [7:0] CODE_UVW = 8'h43;
   localparam logic [7:0] CODE_UVF = 8'h44;
   localparam logic [7:0] CODE_PGON = 8'h5e;
   localparam logic [7:0] CODE_PGOFF = 8'h5f;
   localparam logic [7:0] CODE_MAX = 8'ha5;
   localparam logic [7:0] CODE_VIN_OV = 8'h55;
   localparam logic [7:0] CODE_VIN_UV = 8'h58;
   localparam logic [7:0] CODE_IN_ON = 8'h35;
   localparam logic [7:0] CODE_IN_OFF = 8'h36;
   localparam logic [3:0] IX_NOM = 4'h0;
   localparam logic [3:0] IX_CEIL = 4'h1;
   localparam logic [3:0] IX_MHI = 4'h2;
   localparam logic [3:0] IX_MLO = 4'h3;
   localparam logic [3:0] IX_OVF = 4'h4;
   localparam logic [3:0] IX_OVW = 4'h5;
   localparam logic [3:0] IX_UVW = 4'h6;
   localparam logic [3:0] IX_UVF = 4'h7;
   localparam logic [3:0] IX_PGON = 4'h8;
   localparam logic [3:0] IX_PGOFF = 4'h9;
   localparam logic [1:0] IV_OV = 2'h0;
   localparam logic [1:0] IV_UV = 2'h1;
   localparam logic [1:0] IV_ON = 2'h2;
   localparam logic [1:0] IV_OFF = 2'h3;
   localparam logic [15:0] RST_NOM = 16'h1000;
   localparam logic [15:0] RST_CEIL0 = 16'h4189;
   localparam logic [15:0] RST_CEIL1 = 16'h5800;
   localparam logic [15:0] RST_MHI = 16'h10cd;
   localparam logic [15:0] RST_MLO = 16'h0f33;
   localparam logic [15:0] RST_OVF = 16'h119a;
   localparam logic [15:0] RST_OVW = 16'h1133;
   localparam logic [15:0] RST_UVW = 16'h0ecd;
   localparam logic [15:0] RST_UVF = 16'h0e66;
   localparam logic [15:0] RST_PGON = 16'h0ee1;
   localparam logic [15:0] RST_PGOFF = 16'h0eb8;
   localparam logic [15:0] RST_VIN_OV = 16'hd3e0;
   localparam logic [15:0] RST_VIN_UV = 16'hcb26;
   localparam logic [15:0] RST_IN_ON = 16'hcb40;
   localparam logic [15:0] RST_IN_OFF = 16'hcb00;
   localparam logic [7:0] FMT_VALUE = 8'h14;
   localparam logic [15:0] MAX_ALLOWED0 = 16'h4189;
   localparam logic [15:0] MAX_ALLOWED1 = 16'h5800;
   localparam int OVF_BIT = 7;
   localparam int OVW_BIT = 6;
   localparam int UVW_BIT = 5;
   localparam int UVF_BIT = 4;
   localparam int BUSY_BIT_A = 5;
   localparam int BUSY_BIT_B = 6;
   localparam logic [7:0] IDLE_FLAGS = 8'h60;
   localparam int CLK_NS = 50;
   localparam int RECALC_NS = 800;
   localparam logic [4:0] RECALC_CYC = 5'((RECALC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RAMP_STEP = 16'h0010;
   localparam logic [1:0] OP_MARGIN_LOW = 2'b01;
   localparam logic [1:0] OP_MARGIN_HIGH = 2'b10;
   typedef enum logic [1:0] {
      CH_OFF = 2'b00,
      CH_RISE = 2'b01,
      CH_ON = 2'b10,
      CH_FALL = 2'b11
   } ch_state_e;
endpackage

// File: rtl/voltage_limit_setpoint_regs.sv
// Voltage limit and setpoint bank for a two-channel controller.
// Assumes a command engine on link_clk and converter samples on clk.
`timescale 1ns/1ps
module voltage_limit_setpoint_regs (
   // Core clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command port on the link clock
   input wire logic link_clk,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic cmd_page,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   output logic link_busy_ff,
   output logic rsp_valid_ff,
   output logic rsp_ok_ff,
   output logic [15:0] rsp_data_ff,
   // Converter samples
   input wire logic vin_valid,
   input wire logic [15:0] vin_sample,
   input wire logic [1:0] vout_valid,
   input wire logic [1:0][15:0] vout_sample,
   // Controls
   input wire logic [1:0] op_mode,
   input wire logic [1:0] ch_enable,
   input wire logic overvolt_pull_down_choice,
   input wire logic [15:0] output_slew_rate,
   input wire logic clear_faults,
   // Status and drive
   output logic conv_on_ff,
   output logic vin_ov_fault_ff,
   output logic vin_uv_warn_ff,
   output logic [1:0][15:0] vout_cmd_ff,
   output logic [1:0] power_good_ff,
   output logic [1:0][7:0] output_voltage_flags_ff,
   output logic catch_all_flag_ff,
   output logic vout_summary_ff,
   output logic alert_ff,
   output logic [7:0] common_status_flags_ff,
   output logic [1:0] top_gate_drive_ff,
   output logic [1:0] bottom_gate_drive_ff,
   output logic fault_pin_ff
);
   import vlimit_pkg::*;

   function automatic logic signed [47:0] l11_fix(input logic [15:0] w);
      logic signed [47:0] m;
      logic [4:0] sh;
      m = 48'(signed'(w[10:0]));
      // Exponent plus 16, so every legal word lands on one scale
      sh = w[15:11] ^ 5'h10;
      l11_fix = m <<< sh;
   endfunction

   function automatic logic [15:0] min16(input logic [15:0] a, b);
      min16 = (a < b) ? a : b;
   endfunction

   function automatic logic [15:0] max_allowed(input logic ch);
      max_allowed = ch ? MAX_ALLOWED1 : MAX_ALLOWED0;
   endfunction

   function automatic logic [15:0] slew(input logic [15:0] cur, tgt, step);
      logic [16:0] up;
      up = {1'b0, cur} + {1'b0, step};
      if (cur < tgt)
         slew = (up >= {1'b0, tgt}) ? tgt : up[15:0];
      else
         slew = ((cur - tgt) > step) ? cur - step : tgt;
   endfunction

   // {hit, shared, index}
   function automatic logic [5:0] word_idx(input logic [7:0] code);
      case (code)
         CODE_NOM: word_idx = {2'b10, IX_NOM};
         CODE_CEIL: word_idx = {2'b10, IX_CEIL};
         CODE_MHI: word_idx = {2'b10, IX_MHI};
         CODE_MLO: word_idx = {2'b10, IX_MLO};
         CODE_OVF: word_idx = {2'b10, IX_OVF};
         CODE_OVW: word_idx = {2'b10, IX_OVW};
         CODE_UVW: word_idx = {2'b10, IX_UVW};
         CODE_UVF: word_idx = {2'b10, IX_UVF};
         CODE_PGON: word_idx = {2'b10, IX_PGON};
         CODE_PGOFF: word_idx = {2'b10, IX_PGOFF};
         CODE_VIN_OV: word_idx = {4'b1100, IV_OV};
         CODE_VIN_UV: word_idx = {4'b1100, IV_UV};
         CODE_IN_ON: word_idx = {4'b1100, IV_ON};
         CODE_IN_OFF: word_idx = {4'b1100, IV_OFF};
         default: word_idx = 6'h00;
      endcase
   endfunction

   function automatic logic [15:0] rst_word(input logic ch, logic [3:0] ix);
      case (ix)
         IX_NOM: rst_word = RST_NOM;
         IX_CEIL: rst_word = ch ? RST_CEIL1 : RST_CEIL0;
         IX_MHI: rst_word = RST_MHI;
         IX_MLO: rst_word = RST_MLO;
         IX_OVF: rst_word = RST_OVF;
         IX_OVW: rst_word = RST_OVW;
         IX_UVW: rst_word = RST_UVW;
         IX_UVF: rst_word = RST_UVF;
         IX_PGON: rst_word = RST_PGON;
         default: rst_word = RST_PGOFF;
      endcase
   endfunction

   logic [15:0] regs_ff [2][10];
   logic [15:0] vin_ff [4];
   logic req_tgl_ff, l_wr_ff, l_page_ff;
   logic [7:0] l_code_ff;
   logic [15:0] l_wdata_ff;
   logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
   logic req_s1_ff, req_s2_ff, req_s3_ff;
   logic ack_tgl_ff, c_ok_ff;
   logic [15:0] c_rdata_ff;
   logic [4:0] busy_cnt_ff;
   logic req_edge, hit, shared, do_wr, ovf_wr;
   logic [3:0] idx;
   logic [15:0] rd_word, wr_val;
   logic signed [47:0] vin_fix;
   logic [1:0] ev_ovf, ev_ovw, ev_uvw, ev_uvf, run_req;
   logic [1:0][15:0] want, nxt_cmd, tgt_ff, nxt_tgt;
   ch_state_e st_ff [2];
   ch_state_e nxt_st [2];

   // Link side: hold the request until the core answers
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         req_tgl_ff <= 1'b0;
         l_wr_ff <= 1'b0;
         l_page_ff <= 1'b0;
         l_code_ff <= 8'h00;
         l_wdata_ff <= 16'h0000;
         link_busy_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_ok_ff <= 1'b0;
         rsp_data_ff <= 16'h0000;
      end
      else
      begin
         rsp_valid_ff <= 1'b0;
         if (cmd_valid && !link_busy_ff)
         begin
            l_wr_ff <= cmd_write;
            l_page_ff <= cmd_page;
            l_code_ff <= cmd_code;
            l_wdata_ff <= cmd_wdata;
            req_tgl_ff <= ~req_tgl_ff;
            link_busy_ff <= 1'b1;
         end
         else if (link_busy_ff && (ack_s2_ff != ack_s3_ff))
         begin
            link_busy_ff <= 1'b0;
            rsp_valid_ff <= 1'b1;
            rsp_ok_ff <= c_ok_ff;
            rsp_data_ff <= c_rdata_ff;
         end
      end
   end

   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         ack_s3_ff <= 1'b0;
      end
      else
      begin
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_s3_ff <= ack_s2_ff;
      end
   end

   // Request fields stay still while the toggle is in flight
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_s3_ff <= 1'b0;
      end
      else
      begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
      end
   end

   always_comb
   begin
      req_edge = req_s2_ff ^ req_s3_ff;
      {hit, shared, idx} = word_idx(l_code_ff);
      if (!hit)
         rd_word = (l_code_ff == CODE_FMT) ? {8'h00, FMT_VALUE} :
            (l_code_ff == CODE_MAX) ? max_allowed(l_page_ff) : 16'h0000;
      else if (shared)
         rd_word = vin_ff[idx[1:0]];
      else
         rd_word = regs_ff[l_page_ff][idx];
      wr_val = (!shared && idx <= IX_OVF) ?
         min16(l_wdata_ff, max_allowed(l_page_ff)) : l_wdata_ff;
      do_wr = req_edge && l_wr_ff && hit;
      ovf_wr = do_wr && !shared && idx == IX_OVF;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < 2; c++)
            for (int i = 0; i < 10; i++)
               regs_ff[c][i] <= rst_word(1'(c), 4'(i));
         vin_ff[IV_OV] <= RST_VIN_OV;
         vin_ff[IV_UV] <= RST_VIN_UV;
         vin_ff[IV_ON] <= RST_IN_ON;
         vin_ff[IV_OFF] <= RST_IN_OFF;
      end
      else if (do_wr)
      begin
         if (shared)
            vin_ff[idx[1:0]] <= l_wdata_ff;
         else
            regs_ff[l_page_ff][idx] <= wr_val;
      end
   end

   // Read-only words refuse writes with ok low
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ack_tgl_ff <= 1'b0;
         c_ok_ff <= 1'b0;
         c_rdata_ff <= 16'h0000;
      end
      else if (req_edge)
      begin
         ack_tgl_ff <= ~ack_tgl_ff;
         c_rdata_ff <= l_wr_ff ? 16'h0000 : rd_word;
         c_ok_ff <= hit || (!l_wr_ff &&
            (l_code_ff == CODE_FMT || l_code_ff == CODE_MAX));
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busy_cnt_ff <= 5'h00;
         common_status_flags_ff <= IDLE_FLAGS;
      end
      else if (ovf_wr)
      begin
         busy_cnt_ff <= RECALC_CYC;
         common_status_flags_ff <= 8'h00;
      end
      else if (busy_cnt_ff > 5'h01)
         busy_cnt_ff <= busy_cnt_ff - 5'h01;
      else
      begin
         busy_cnt_ff <= 5'h00;
         common_status_flags_ff <= IDLE_FLAGS;
      end
   end

   // Input monitor; a detection in the clearing cycle still lands
   always_comb
   begin
      vin_fix = l11_fix(vin_sample);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         vin_ov_fault_ff <= 1'b0;
         vin_uv_warn_ff <= 1'b0;
         conv_on_ff <= 1'b0;
      end
      else
      begin
         vin_ov_fault_ff <= (vin_ov_fault_ff && !clear_faults) ||
            (vin_valid && vin_fix > l11_fix(vin_ff[IV_OV]));
         vin_uv_warn_ff <= (vin_uv_warn_ff && !clear_faults) ||
            (vin_valid && vin_fix < l11_fix(vin_ff[IV_UV]));
         if (vin_valid && vin_fix >= l11_fix(vin_ff[IV_ON]))
            conv_on_ff <= 1'b1;
         else if (vin_valid && vin_fix <= l11_fix(vin_ff[IV_OFF]))
            conv_on_ff <= 1'b0;
      end
   end

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         ev_ovf[c] = vout_valid[c] && vout_sample[c] > regs_ff[c][IX_OVF];
         ev_ovw[c] = vout_valid[c] && vout_sample[c] > regs_ff[c][IX_OVW];
         ev_uvw[c] = vout_valid[c] && vout_sample[c] < regs_ff[c][IX_UVW];
         ev_uvf[c] = vout_valid[c] && vout_sample[c] < regs_ff[c][IX_UVF];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         output_voltage_flags_ff <= '0;
         power_good_ff <= 2'b00;
      end
      else
         for (int c = 0; c < 2; c++)
         begin
            output_voltage_flags_ff[c][OVF_BIT] <= ev_ovf[c] ||
               (output_voltage_flags_ff[c][OVF_BIT] && !clear_faults);
            output_voltage_flags_ff[c][OVW_BIT] <= ev_ovw[c] ||
               (output_voltage_flags_ff[c][OVW_BIT] && !clear_faults);
            output_voltage_flags_ff[c][UVW_BIT] <= ev_uvw[c] ||
               (output_voltage_flags_ff[c][UVW_BIT] && !clear_faults);
            output_voltage_flags_ff[c][UVF_BIT] <= ev_uvf[c] ||
               (output_voltage_flags_ff[c][UVF_BIT] && !clear_faults);
            if (vout_valid[c] && vout_sample[c] >= regs_ff[c][IX_PGON])
               power_good_ff[c] <= 1'b1;
            else if (vout_valid[c] &&
               vout_sample[c] <= regs_ff[c][IX_PGOFF])
               power_good_ff[c] <= 1'b0;
         end
   end

   // Power-good is kept off the alert line
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         catch_all_flag_ff <= 1'b0;
         vout_summary_ff <= 1'b0;
         alert_ff <= 1'b0;
         fault_pin_ff <= 1'b0;
      end
      else
      begin
         catch_all_flag_ff <= (catch_all_flag_ff && !clear_faults) ||
            |(ev_ovw | ev_uvw);
         vout_summary_ff <= (vout_summary_ff && !clear_faults) ||
            |(ev_ovw | ev_uvw | ev_ovf | ev_uvf);
         alert_ff <= (alert_ff && !clear_faults) ||
            |(ev_ovw | ev_uvw | ev_ovf | ev_uvf) ||
            (vin_valid && vin_fix > l11_fix(vin_ff[IV_OV])) ||
            (vin_valid && vin_fix < l11_fix(vin_ff[IV_UV]));
         fault_pin_ff <= (fault_pin_ff && !clear_faults) ||
            (|ev_ovf && !overvolt_pull_down_choice);
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         top_gate_drive_ff <= 2'b00;
         bottom_gate_drive_ff <= 2'b00;
      end
      else
         for (int c = 0; c < 2; c++)
         begin
            top_gate_drive_ff[c] <= (st_ff[c] != CH_OFF) && !ev_ovf[c] &&
               !output_voltage_flags_ff[c][OVF_BIT];
            bottom_gate_drive_ff[c] <= overvolt_pull_down_choice &&
               (ev_ovf[c] || output_voltage_flags_ff[c][OVF_BIT]);
         end
   end

   // Channel sequencing; a latched output overvoltage fault shuts the channel down
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (op_mode == OP_MARGIN_HIGH)
            want[c] = regs_ff[c][IX_MHI];
         else if (op_mode == OP_MARGIN_LOW)
            want[c] = regs_ff[c][IX_MLO];
         else
            want[c] = regs_ff[c][IX_NOM];
         want[c] = min16(want[c], regs_ff[c][IX_CEIL]);
         run_req[c] = conv_on_ff && ch_enable[c] &&
            !output_voltage_flags_ff[c][OVF_BIT];
         nxt_st[c] = st_ff[c];
         nxt_tgt[c] = tgt_ff[c];
         nxt_cmd[c] = vout_cmd_ff[c];
         case (st_ff[c])
            CH_OFF:
            begin
               nxt_cmd[c] = 16'h0000;
               if (run_req[c])
               begin
                  nxt_st[c] = CH_RISE;
                  nxt_tgt[c] = want[c];
               end
            end
            CH_RISE:
            begin
               // Target frozen until the ramp ends
               nxt_cmd[c] = slew(vout_cmd_ff[c], tgt_ff[c], RAMP_STEP);
               if (!run_req[c])
                  nxt_st[c] = CH_FALL;
               else if (nxt_cmd[c] == tgt_ff[c])
                  nxt_st[c] = CH_ON;
            end
            CH_ON:
            begin
               nxt_tgt[c] = want[c];
               nxt_cmd[c] = slew(vout_cmd_ff[c], want[c],
                  output_slew_rate);
               if (!run_req[c])
                  nxt_st[c] = CH_FALL;
            end
            CH_FALL:
            begin
               nxt_cmd[c] = slew(vout_cmd_ff[c], 16'h0000, RAMP_STEP);
               if (nxt_cmd[c] == 16'h0000)
                  nxt_st[c] = CH_OFF;
            end
            default:
               nxt_st[c] = CH_OFF;
         endcase
         nxt_cmd[c] = min16(nxt_cmd[c], regs_ff[c][IX_CEIL]);
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < 2; c++)
            st_ff[c] <= CH_OFF;
         tgt_ff <= '0;
         vout_cmd_ff <= '0;
      end
      else
      begin
         for (int c = 0; c < 2; c++)
            st_ff[c] <= nxt_st[c];
         tgt_ff <= nxt_tgt;
         vout_cmd_ff <= nxt_cmd;
      end
   end

   a_fmt_read: assert property (@(posedge clk) disable iff (rst)
      req_edge && !l_wr_ff && l_code_ff == CODE_FMT
      |=> c_rdata_ff == {8'h00, FMT_VALUE})
      else $error("format byte read wrong");
   a_vin_ov_set: assert property (@(posedge clk) disable iff (rst)
      vin_valid && vin_fix > l11_fix(vin_ff[IV_OV]) |=> vin_ov_fault_ff)
      else $error("input overvoltage missed");
   a_conv_start: assert property (@(posedge clk) disable iff (rst)
      vin_valid && vin_fix >= l11_fix(vin_ff[IV_ON]) |=> conv_on_ff)
      else $error("conversion did not start");
   a_conv_stop: assert property (@(posedge clk) disable iff (rst)
      vin_valid && vin_fix <= l11_fix(vin_ff[IV_OFF]) &&
      vin_fix < l11_fix(vin_ff[IV_ON]) |=> !conv_on_ff)
      else $error("conversion did not stop");
   a_ceiling_cap: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> vout_cmd_ff[0] <= $past(regs_ff[0][IX_CEIL]))
      else $error("output above ceiling");
   a_busy_window: assert property (@(posedge clk) disable iff (rst)
      ovf_wr && !$past(ovf_wr) |=> !common_status_flags_ff[BUSY_BIT_A] &&
      !common_status_flags_ff[BUSY_BIT_B] ##16
      common_status_flags_ff[BUSY_BIT_A] || $past(ovf_wr, 16))
      else $error("busy bits wrong");
   a_pull_down: assert property (@(posedge clk) disable iff (rst)
      overvolt_pull_down_choice |=> (bottom_gate_drive_ff &
      ~top_gate_drive_ff & $past(ev_ovf)) == $past(ev_ovf))
      else $error("pull-down reaction missing");
   a_warn_alert: assert property (@(posedge clk) disable iff (rst)
      ev_ovw[0] |=> alert_ff && catch_all_flag_ff && vout_summary_ff &&
      output_voltage_flags_ff[0][OVW_BIT])
      else $error("overvoltage warning not flagged");
   a_rise_hold: assert property (@(posedge clk) disable iff (rst)
      st_ff[0] == CH_RISE && $past(st_ff[0]) == CH_RISE |-> $stable(tgt_ff[0]))
      else $error("target moved during ramp");
   a_pg_on: assert property (@(posedge clk) disable iff (rst)
      vout_valid[0] && vout_sample[0] >= regs_ff[0][IX_PGON]
      |=> power_good_ff[0])
      else $error("power good not set");

   c_rise_on: cover property (@(posedge clk) disable iff (rst)
      st_ff[0] == CH_RISE ##1 st_ff[0] == CH_ON);
   c_recalc: cover property (@(posedge clk) disable iff (rst) ovf_wr);
   c_answer: cover property (@(posedge link_clk) disable iff (rst)
      rsp_valid_ff && rsp_ok_ff);
endmodule // voltage_limit_setpoint_regs

// File: test/host_model.sv
// Host model: one word command at a time on the link clock.
// Assumes the block answers within 20 link cycles.
`timescale 1ns/1ps
module host_model (
   // Answer
   input wire logic link_clk,
   input wire logic rsp_valid_ff,
   input wire logic rsp_ok_ff,
   input wire logic [15:0] rsp_data_ff,
   // Request
   output logic cmd_valid = 1'b0,
   output logic cmd_write = 1'b0,
   output logic cmd_page = 1'b0,
   output logic [7:0] cmd_code = 8'h00,
   output logic [15:0] cmd_wdata = 16'h0000
);
   task automatic xfer(input logic w, input logic p, input logic [7:0] c,
      input logic [15:0] d, output logic ok, output logic [15:0] q);
      int n;
      @(posedge link_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_page <= p;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge link_clk);
      cmd_valid <= 1'b0;
      // Stale data inverted so it never passes for a live word
      cmd_wdata <= ~d;
      n = 0;
      do
      begin
         @(posedge link_clk);
         n++;
      end
      while (rsp_valid_ff !== 1'b1 && n < 20);
      ok = (n < 20) ? rsp_ok_ff : 1'bx;
      // Unknown on timeout so a stale word never passes a compare
      q = (n < 20) ? rsp_data_ff : 16'hxxxx;
   endtask
endmodule // host_model

// File: test/tb_voltage_limit_setpoint_regs.sv
// Bench: command calls plus converter sample pulses.
// Assumes channel 1 stays disabled; channel 0 ramps once at the end.
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
 bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_voltage_limit_setpoint_regs;
   logic clk = 0, link_clk = 0, rst = 1, vin_valid = 0, clear_faults = 0;
   logic cmd_valid, cmd_write, cmd_page, link_busy_ff, rsp_valid_ff, ok;
   logic rsp_ok_ff, conv_on_ff, vin_ov_fault_ff, vin_uv_warn_ff, pd = 0;
   logic catch_all_flag_ff, vout_summary_ff, alert_ff, fault_pin_ff;
   logic [7:0] cmd_code, common_status_flags_ff;
   logic [15:0] cmd_wdata, rsp_data_ff, q, vin_sample = 0;
   logic [1:0] vout_valid = 0, power_good_ff, op = 0, en = 0;
   logic [1:0] top_gate_drive_ff, bottom_gate_drive_ff;
   logic [1:0][15:0] vout_sample = 0, vout_cmd_ff;
   logic [1:0][7:0] output_voltage_flags_ff;
   logic [7:0] cds [10] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h40, 8'h42,
      8'h43, 8'h44, 8'h5e, 8'h5f};
   logic [15:0] rvs [10] = '{16'h1000, 16'h4189, 16'h10cd, 16'h0f33,
      16'h119a, 16'h1133, 16'h0ecd, 16'h0e66, 16'h0ee1, 16'h0eb8};
   int bad_count = 0, cmp_count = 0;
   voltage_limit_setpoint_regs uut (.*, .op_mode(op), .ch_enable(en),
      .overvolt_pull_down_choice(pd), .output_slew_rate(16'h0010));
   host_model host (.*);
   initial forever #25 clk = ~clk;
   initial
   begin
      #7;
      forever #15 link_clk = ~link_clk;
   end
   task automatic rd(logic p, logic [7:0] c, logic [15:0] e);
      host.xfer(1'b0, p, c, 16'h0000, ok, q);
      `CHK("read", e, q)
   endtask
   task automatic wr(logic p, logic [7:0] c, logic [15:0] d);
      host.xfer(1'b1, p, c, d, ok, q);
   endtask
   // Bit 1 of k selects the input sample, else k[0] picks the channel
   task automatic smp(logic [1:0] k, logic [15:0] v);
      @(posedge clk);
      vin_sample <= v;
      vin_valid <= k[1];
      vout_sample[k[0]] <= v;
      vout_valid[k[0]] <= ~k[1];
      @(posedge clk);
      vin_valid <= 1'b0;
      vout_valid <= 2'b00;
      #1;
   endtask
   task automatic clr;
      @(posedge clk);
      clear_faults <= 1'b1;
      @(posedge clk);
      clear_faults <= 1'b0;
      #1;
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Whole run needs well under 50 us
   initial
   begin
      #200000;
      bad_count++;
      finish_test;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge link_clk);
      for (int i = 0; i < 10; i++) rd(1'b0, cds[i], rvs[i]);
      rd(1'b1, 8'h24, 16'h5800);
      rd(1'b1, 8'ha5, 16'h5800);
      rd(1'b0, 8'ha5, 16'h4189);
      wr(1'b0, 8'h20, 16'hffff);
      `CHK("fmt ok", 1'b0, ok)
      rd(1'b0, 8'h20, 16'h0014);
      $display("test words done");
      // Page 1 nominal kept between both margins
      wr(1'b1, 8'h21, 16'h0f80);
      rd(1'b0, 8'h21, 16'h1000);
      rd(1'b1, 8'h21, 16'h0f80);
      wr(1'b1, 8'h25, 16'hffff);
      rd(1'b1, 8'h25, 16'h5800);
      wr(1'b0, 8'h55, 16'hd3f0);
      rd(1'b1, 8'h55, 16'hd3f0);
      wr(1'b0, 8'h40, 16'h1200);
      `CHK("busy", 8'h00, common_status_flags_ff)
      // Busy bits return to idle only after the recalculation window
      repeat (20) @(posedge clk);
      #1 `CHK("idle", 8'h60, common_status_flags_ff)
      $display("test paging done");
      smp(2'b00, 16'h1133);
      `CHK("ovw edge", 8'h00, output_voltage_flags_ff[0])
      smp(2'b00, 16'h1134);
      `CHK("ovw", 8'h40, output_voltage_flags_ff[0])
      `CHK("sum", 3'b111, {catch_all_flag_ff, vout_summary_ff,
         alert_ff})
      smp(2'b00, 16'h0eb9);
      `CHK("pg hold", 1'b1, power_good_ff[0])
      smp(2'b00, 16'h0eb8);
      `CHK("pg off", 1'b0, power_good_ff[0])
      smp(2'b00, 16'h0e65);
      `CHK("uv", 8'h70, output_voltage_flags_ff[0])
      clr;
      `CHK("clr", 1'b0, alert_ff)
      @(posedge clk);
      pd <= 1'b1;
      smp(2'b01, 16'h119b);
      `CHK("ovf", 8'hc0, output_voltage_flags_ff[1])
      `CHK("gates", 3'b010, {top_gate_drive_ff[1], bottom_gate_drive_ff[1],
         fault_pin_ff})
      $display("test events done");
      smp(2'b10, 16'hcb40);
      `CHK("on", 1'b1, conv_on_ff)
      smp(2'b10, 16'hcb25);
      `CHK("vin uv", 2'b11, {vin_uv_warn_ff, conv_on_ff})
      smp(2'b10, 16'hcb00);
      `CHK("off", 1'b0, conv_on_ff)
      smp(2'b10, 16'hd3f1);
      `CHK("vin ov", 1'b1, vin_ov_fault_ff)
      $display("test input done");
      smp(2'b10, 16'hcb40);
      @(posedge clk);
      en <= 2'b01;
      // Nominal changed mid-rise; ramp must still end at the old target
      wr(1'b0, 8'h21, 16'h0f40);
      repeat (250) @(posedge clk);
      #1 `CHK("defer", 1'b1, vout_cmd_ff[0] > 16'h0f40)
      `CHK("tg", 1'b1, top_gate_drive_ff[0])
      @(posedge clk);
      op <= 2'b10;
      repeat (40) @(posedge clk);
      #1 `CHK("margin", 16'h10cd, vout_cmd_ff[0])
      wr(1'b0, 8'h24, 16'h1080);
      `CHK("ceiling", 16'h1080, vout_cmd_ff[0])
      $display("test ramp done");
      finish_test;
   end
endmodule // tb_voltage_limit_setpoint_regs
